// >>> core/ssp_pkg.sv
package ssp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_CLR = 8'h10;
  localparam logic [7:0] ADDR_INT_EN = 8'h14;
  localparam logic [7:0] ADDR_CLKDIV = 8'h18;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_ON = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_CPOL = 2;
  localparam int CTRL_CPHA = 3;
  localparam int CTRL_WIDTH_LO = 4;
  localparam int CTRL_ENHANCED_BUFFER_ENABLE = 6;
  localparam int CTRL_FRAMED_MODE_ENABLE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int ST_RXCNT_LO = 24;
  localparam int ST_TXCNT_LO = 16;
  localparam int ST_FRAME_ERROR_FLAG = 12;
  localparam int ST_BUSY = 11;
  localparam int ST_TUR = 8;
  localparam int ST_SHIFTER_EMPTY_FLAG = 7;
  localparam int ST_ROV = 6;
  localparam int ST_RBE = 5;
  localparam int ST_TBE = 3;
  localparam int ST_TBF = 1;
  localparam int ST_RBF = 0;
  // interrupt events
  localparam int IRQ_XFER = 0;
  localparam int IRQ_ROV = 1;
  localparam int IRQ_FRAME_ERROR_FLAG = 2;
  localparam int IRQ_TUR = 3;
  localparam int IRQ_N = 4;
  // ---------------------------------------------------------------
  // fifo depths, byte storage of 16 bytes
  // ---------------------------------------------------------------
  localparam int FIFO_BYTES = 16;
  localparam logic [4:0] DEPTH_8 = 5'h10;
  localparam logic [4:0] DEPTH_16 = 5'h08;
  localparam logic [4:0] DEPTH_32 = 5'h04;
  localparam logic [7:0] CLKDIV_RESET = 8'h04;
endpackage

// >>> core/ssp_core.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - port runs as master driving serial clock or slave following external clock
// - four clock formats from idle polarity and sampling edge selections
// - software selects 8, 16 or 32 bit words
// - separate rx and tx fifos, 4/8/16 deep at 32/16/8 bit width
// - interrupt event raised on completion of every word transfer
// - port keeps running in sleep and idle, no gating by power state
// - status bits 28..24 give rx fifo word count
// - status bits 20..16 give tx fifo word count
// - status bit 12 frame error, set by hardware, cleared by software
// - status bit 11 high while a transaction is in progress
// - status bit 8 tx underrun, cleared only by turning port off and on
// - status bit 7 high when shift register holds nothing pending
// - status bit 6 set when a word arrives with rx fifo full; word dropped
// - overflow flag set only by hardware, software may only clear it
// - status bit 5 high when rx fifo empty, rx word count zero
// - status bits 31..29 and other undefined bits read zero
module ssp_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic irq
);
  import ssp_pkg::*;

  // ---------------------------------------------------------------
  // registers and apb decode
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] clkdiv_r;
  logic [IRQ_N-1:0] int_stat_r;
  logic [IRQ_N-1:0] int_en_r;
  logic rov_r, frame_error_flag_r, tur_r;
  // act once, in the access cycle that raises pready, so pushes and pops are not repeated
  wire acc = psel && penable && !pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_status = paddr == ADDR_STATUS;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_data = paddr == ADDR_DATA;
  wire hit_istat = paddr == ADDR_INT_STAT;
  wire hit_iclr = paddr == ADDR_INT_CLR;
  wire hit_ien = paddr == ADDR_INT_EN;
  wire hit_div = paddr == ADDR_CLKDIV;
  wire hit_any = hit_status | hit_ctrl | hit_data | hit_istat | hit_iclr | hit_ien | hit_div;
  wire port_on = ctrl_r[CTRL_ON];
  wire is_master = ctrl_r[CTRL_MASTER];
  wire cpol = ctrl_r[CTRL_CPOL];
  wire cpha = ctrl_r[CTRL_CPHA];
  wire [1:0] wsel = ctrl_r[CTRL_WIDTH_LO +: 2];
  // width code 3 is treated as 8 bits
  wire [4:0] depth = (wsel == WIDTH_32) ? DEPTH_32 : (wsel == WIDTH_16) ? DEPTH_16 : DEPTH_8;
  wire [5:0] nbits = (wsel == WIDTH_32) ? 6'h20 : (wsel == WIDTH_16) ? 6'h10 : 6'h08;

  // ---------------------------------------------------------------
  // fifos: word entries, 16 slots of 32 bits, depth limited by width
  // ---------------------------------------------------------------
  logic [31:0] txm [FIFO_BYTES];
  logic [31:0] rxm [FIFO_BYTES];
  logic [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [4:0] tx_cnt_r, rx_cnt_r;
  wire tx_full = tx_cnt_r >= depth;
  wire tx_empty = tx_cnt_r == 5'h00;
  wire rx_full = rx_cnt_r >= depth;
  wire rx_empty = rx_cnt_r == 5'h00;
  wire tx_push = wr && hit_data && !tx_full && port_on;
  wire rx_pop = rd && hit_data && !rx_empty;
  logic word_done;
  logic [31:0] rx_word;
  logic load_shift;
  wire rx_push = word_done && !rx_full;
  wire rov_evt = word_done && rx_full;
  wire tx_pop = load_shift;

  genvar gi;
  generate
    for (gi = 0; gi < FIFO_BYTES; gi++) begin : g_mem
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          txm[gi] <= 32'h0;
          rxm[gi] <= 32'h0;
        end else begin
          if (tx_push && tx_wp_r == 4'(gi)) txm[gi] <= pwdata;
          if (rx_push && rx_wp_r == 4'(gi)) rxm[gi] <= rx_word;
        end
      end
    end
  endgenerate

  // pointers wrap at the width's depth, so a width change needs a port off
  wire [3:0] dmax = 4'(depth - 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_r <= 4'h0;
      tx_rp_r <= 4'h0;
      rx_wp_r <= 4'h0;
      rx_rp_r <= 4'h0;
      tx_cnt_r <= 5'h00;
      rx_cnt_r <= 5'h00;
    end else if (!port_on) begin
      tx_wp_r <= 4'h0;
      tx_rp_r <= 4'h0;
      rx_wp_r <= 4'h0;
      rx_rp_r <= 4'h0;
      tx_cnt_r <= 5'h00;
      rx_cnt_r <= 5'h00;
    end else begin
      if (tx_push) tx_wp_r <= (tx_wp_r == dmax) ? 4'h0 : tx_wp_r + 4'h1;
      if (tx_pop) tx_rp_r <= (tx_rp_r == dmax) ? 4'h0 : tx_rp_r + 4'h1;
      if (rx_push) rx_wp_r <= (rx_wp_r == dmax) ? 4'h0 : rx_wp_r + 4'h1;
      if (rx_pop) rx_rp_r <= (rx_rp_r == dmax) ? 4'h0 : rx_rp_r + 4'h1;
      tx_cnt_r <= tx_cnt_r + 5'(tx_push) - 5'(tx_pop);
      rx_cnt_r <= rx_cnt_r + 5'(rx_push) - 5'(rx_pop);
    end
  end

  // ---------------------------------------------------------------
  // link input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sck_s1, sck_s2;
  wire [2:0] pins = {sck_in, sdi, ss_n_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1 <= 3'h1;
      sck_s2 <= 3'h1;
    end else begin
      sck_s1 <= pins;
      sck_s2 <= sck_s1;
    end
  end
  wire sck_sync = sck_s2[2];
  wire sdi_sync = sck_s2[1];
  wire ss_sync_n = sck_s2[0];
  logic sck_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sck_prev_r <= 1'b0;
    else sck_prev_r <= sck_sync;
  end

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_SHIFT = 3'b010,
    SSP_DONE = 3'b100
  } ssp_state_t;
  ssp_state_t state_r;
  logic [31:0] tx_sh_r, rx_sh_r;
  logic [5:0] bit_cnt_r;
  logic [7:0] div_cnt_r;
  logic sck_r, busy_r, shift_full_r;
  // master clock enable: one pulse per half period
  // sdi is sampled through its synchroniser: a half period under 4 cycles misses the round trip
  wire half_tick = div_cnt_r == clkdiv_r;
  wire lead_m = is_master && half_tick && (sck_r == cpol);
  wire trail_m = is_master && half_tick && (sck_r != cpol);
  // slave edges on the synchronised clock, relative to idle level
  wire s_lead = !is_master && !ss_sync_n && (sck_sync != cpol) && (sck_prev_r == cpol);
  wire s_trail = !is_master && !ss_sync_n && (sck_sync == cpol) && (sck_prev_r != cpol);
  wire lead = lead_m | s_lead;
  wire trail = trail_m | s_trail;
  // cpha=0 samples on leading edge, cpha=1 on trailing edge
  wire sample = cpha ? trail : lead;
  wire change = cpha ? lead : trail;
  wire start_m = is_master && !tx_empty;
  wire start_s = !is_master && !ss_sync_n;
  // a slave started with nothing queued shifts zeros: underrun in framed mode
  wire tur_evt = (state_r == SSP_IDLE) && port_on && start_s && tx_empty && ctrl_r[CTRL_FRAMED_MODE_ENABLE];
  // in framed mode, slave select lifted after the first bit and before the word ends is a framing error
  wire frm_evt = (state_r == SSP_SHIFT) && !is_master && ss_sync_n && (bit_cnt_r != 6'h00)
    && ctrl_r[CTRL_FRAMED_MODE_ENABLE];
  // a released select ends a slave word at once, so busy cannot hang between frames
  wire slave_drop = (state_r == SSP_SHIFT) && !is_master && ss_sync_n;
  wire [31:0] tx_head = txm[tx_rp_r];
  wire [31:0] tx_aligned = tx_head << (6'h20 - nbits);

  assign load_shift = (state_r == SSP_IDLE) && port_on && (start_m || start_s) && !tx_empty;
  assign word_done = (state_r == SSP_DONE);
  assign rx_word = rx_sh_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SSP_IDLE;
      tx_sh_r <= 32'h0;
      rx_sh_r <= 32'h0;
      bit_cnt_r <= 6'h00;
      div_cnt_r <= 8'h00;
      sck_r <= 1'b0;
      busy_r <= 1'b0;
      shift_full_r <= 1'b0;
      sdo <= 1'b0;
    end else if (!port_on) begin
      state_r <= SSP_IDLE;
      busy_r <= 1'b0;
      shift_full_r <= 1'b0;
      sck_r <= cpol;
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= half_tick ? 8'h00 : div_cnt_r + 8'h01;
      case (state_r)
        SSP_IDLE: begin
          sck_r <= cpol;
          if (start_m || start_s) begin
            state_r <= SSP_SHIFT;
            busy_r <= 1'b1;
            shift_full_r <= !tx_empty;
            tx_sh_r <= tx_empty ? 32'h0 : {tx_aligned[30:0], 1'b0};
            sdo <= tx_empty ? 1'b0 : tx_aligned[31];
            bit_cnt_r <= 6'h00;
            div_cnt_r <= 8'h00;
          end
        end
        SSP_SHIFT: begin
          if (is_master && half_tick) sck_r <= !sck_r;
          if (sample) begin
            rx_sh_r <= {rx_sh_r[30:0], sdi_sync};
            bit_cnt_r <= bit_cnt_r + 6'h01;
            if (bit_cnt_r == nbits - 6'h01 && !cpha) state_r <= SSP_DONE;
          end
          if (change && !(cpha && bit_cnt_r == 6'h00 && lead == 1'b0)) begin
            if (!(cpha && bit_cnt_r == 6'h00)) begin
              sdo <= tx_sh_r[31];
              tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            end
          end
          if (sample && cpha && bit_cnt_r == nbits - 6'h01) state_r <= SSP_DONE;
          if (slave_drop) begin
            state_r <= SSP_IDLE;
            busy_r <= 1'b0;
            shift_full_r <= 1'b0;
          end
        end
        SSP_DONE: begin
          // go idle after one cycle, with the clock forced back to its idle level
          state_r <= SSP_IDLE;
          busy_r <= 1'b0;
          shift_full_r <= 1'b0;
          sck_r <= cpol;
        end
        default: state_r <= SSP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sticky status flags, set beats clear
  // ---------------------------------------------------------------
  wire wr_status = wr && hit_status;
  wire [IRQ_N-1:0] evts = {tur_evt, frm_evt, rov_evt, word_done};
  wire [IRQ_N-1:0] iclr = (wr && hit_iclr) ? pwdata[IRQ_N-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rov_r <= 1'b0;
      frame_error_flag_r <= 1'b0;
      tur_r <= 1'b0;
      int_stat_r <= '0;
    end else begin
      // software writes zero to clear; a write of one is ignored
      rov_r <= rov_evt | (rov_r & !(wr_status & !pwdata[ST_ROV]));
      frame_error_flag_r <= frm_evt | (frame_error_flag_r & !(wr_status & !pwdata[ST_FRAME_ERROR_FLAG]));
      tur_r <= tur_evt | (tur_r & port_on);
      int_stat_r <= evts | (int_stat_r & ~iclr);
    end
  end

  // ---------------------------------------------------------------
  // status word and read mux
  // ---------------------------------------------------------------
  logic [31:0] status;
  always_comb begin
    status = 32'h0;
    status[ST_RXCNT_LO +: 5] = rx_cnt_r;
    status[ST_TXCNT_LO +: 5] = tx_cnt_r;
    status[ST_FRAME_ERROR_FLAG] = frame_error_flag_r;
    status[ST_BUSY] = busy_r;
    status[ST_TUR] = tur_r;
    status[ST_SHIFTER_EMPTY_FLAG] = !shift_full_r;
    status[ST_ROV] = rov_r;
    status[ST_RBE] = rx_empty;
    status[ST_TBE] = tx_empty;
    status[ST_TBF] = tx_full;
    status[ST_RBF] = rx_full;
  end
  wire [31:0] rd_mux =
    hit_status ? status :
    hit_ctrl ? {24'h0, ctrl_r} :
    hit_data ? rxm[rx_rp_r] :
    hit_istat ? {28'h0, int_stat_r} :
    hit_ien ? {28'h0, int_en_r} :
    hit_div ? {24'h0, clkdiv_r} : 32'h0;

  // ---------------------------------------------------------------
  // bus and output registers; no power state input gates the port
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      clkdiv_r <= CLKDIV_RESET;
      int_en_r <= '0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      ss_n_out <= 1'b1;
    end else begin
      if (wr && hit_ctrl) ctrl_r <= pwdata[7:0];
      if (wr && hit_div) clkdiv_r <= pwdata[7:0];
      if (wr && hit_ien) int_en_r <= pwdata[IRQ_N-1:0];
      // one wait state: ready is registered in the first access cycle, high in the second
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit_any;
      if (rd) prdata <= rd_mux;
      irq <= |(int_stat_r & int_en_r);
      sck_out <= sck_r;
      sck_oe <= is_master && port_on;
      ss_n_out <= !(is_master && busy_r);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rov_sticky_a: assert property (rov_evt |=> rov_r) else $error("overflow not flagged");
  rov_keep_a: assert property (rov_evt |=> rx_cnt_r == $past(rx_cnt_r) - 5'($past(rx_pop)))
    else $error("overflow word stored");
  rov_noset_a: assert property (!rov_r && !rov_evt |=> !rov_r) else $error("overflow set by software");
  tur_hold_a: assert property (tur_r && port_on |=> tur_r) else $error("underrun cleared while on");
  busy_done_a: assert property (word_done |=> !busy_r) else $error("busy after word");
  depth_lim_a: assert property (tx_cnt_r <= depth || $changed(wsel)) else $error("tx over depth");
  rbe_ptr_a: assert property (rx_cnt_r < depth |-> status[ST_RBE] == (rx_rp_r == rx_wp_r))
    else $error("rx empty mismatch");
  hi_zero_a: assert property (rd && hit_status |=> (prdata & 32'he0e0e614) == 32'h0)
    else $error("reserved bits set");
  xfer_irq_a: assert property (word_done |=> int_stat_r[IRQ_XFER]) else $error("no word event");
  frm_set_a: assert property (frm_evt |=> frame_error_flag_r) else $error("frame error lost");
  busy_idle_a: assert property (busy_r == (state_r != SSP_IDLE))
    else $error("busy disagrees with engine state");
  shifter_empty_flag_idle_a: assert property (state_r == SSP_IDLE |-> status[ST_SHIFTER_EMPTY_FLAG])
    else $error("shift register not empty when idle");
  rx_lim_a: assert property (rx_cnt_r <= depth || $changed(wsel))
    else $error("rx over depth");
  rov_clr_a: assert property (rov_r && !(wr_status && !pwdata[ST_ROV]) |=> rov_r)
    else $error("overflow lost without a clear");
  tx_full_a: assert property (tx_full && !tx_pop && port_on |=> tx_cnt_r == $past(tx_cnt_r))
    else $error("push accepted while full");
  one_pop_a: assert property (rx_pop |=> !rx_pop)
    else $error("rx popped twice in one read");
  ss_sel_a: assert property (is_master && busy_r |=> !ss_n_out)
    else $error("select not driven while master busy");
  cv_word: cover property (word_done);
  cv_rov: cover property (rov_evt);
  cv_tur: cover property (tur_evt);
  cv_frm: cover property (frm_evt);
  cv_slave_word: cover property (word_done && !is_master);
endmodule // ssp_core

// >>> test/ssp_link_partner.sv
`timescale 1ns/1ps
// ------------------------------------------------
// far side of the link: slave to a master port, or master with its own clock
// ------------------------------------------------
module ssp_link_partner (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo,
  input wire logic ss_n_out,
  output logic sck_in,
  output logic sdi,
  output logic ss_n_in
);
  logic [31:0] tx_word = 32'h0;
  logic [31:0] rx_word = 32'h0;
  logic [31:0] sh_r = 32'h0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic skip_r = 1'b0;
  logic last_r = 1'b0;
  int nbits = 8;
  wire sck = sck_oe ? sck_out : sck_in;
  wire sel = sck_oe ? !ss_n_out : !ss_n_in;
  initial begin
    sck_in = 1'b0;
    ss_n_in = 1'b1;
  end
  // word right-aligned, msb leaves first
  always @(posedge sel) begin
    sh_r <= tx_word << (32 - nbits);
    skip_r <= cpha;
  end
  // sample edge from idle level and phase; trailing-phase skips the first shift
  always @(sck) begin
    if (sel && sck == !(cpol ^ cpha)) begin
      rx_word <= {rx_word[30:0], sdo};
    end else if (sel && skip_r) begin
      skip_r <= 1'b0;
    end else if (sel) begin
      sh_r <= sh_r << 1;
    end
  end
  // released line never repeats its last bit
  always @(negedge sel) last_r <= sh_r[31];
  assign sdi = sel ? sh_r[31] : !last_r;
  // link clock 200 ns, stands still outside the frame
  task automatic master_xfer(input int nclk);
    sck_in <= cpol;
    ss_n_in <= 1'b0;
    #200;
    repeat (nclk) begin
      sck_in <= !cpol;
      #100;
      sck_in <= cpol;
      #100;
    end
    #100;
    ss_n_in <= 1'b1;
    #200;
  endtask
endmodule // ssp_link_partner

// >>> test/ssp_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ssp_tb_top;
  import ssp_pkg::*;
  // ------------------------------------------------
  // clock, reset, links
  // ------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, word, exp_tx;
  logic pready, pslverr, irq, sck_in, sck_out, sck_oe, sdi, sdo, ss_n_in, ss_n_out;
  logic [15:0] seed = 16'h004c;
  logic [1:0] wsel;
  logic [31:0] sent [0:4];
  int mismatches = 0, cmp_count = 0, cycles = 0;
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  ssp_core i_ssp_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .irq(irq));
  ssp_link_partner i_ssp_link_partner (.sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo), .ss_n_out(ss_n_out),
    .sck_in(sck_in), .sdi(sdi), .ss_n_in(ss_n_in));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] ctrl_val(input logic [1:0] w, input logic mst, input logic [1:0] md, input logic f);
    return {24'h0, f, 1'b1, w, md[1], md[0], mst, 1'b1};
  endfunction
  function automatic logic [4:0] depth_of(input logic [1:0] w);
    return (w == WIDTH_8) ? DEPTH_8 : (w == WIDTH_16) ? DEPTH_16 : DEPTH_32;
  endfunction
  function automatic logic [31:0] mask_of(input logic [1:0] w);
    return (w == WIDTH_8) ? 32'hff : (w == WIDTH_16) ? 32'hffff : 32'hffffffff;
  endfunction
  task automatic get_rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    word = {seed, seed ^ 16'h5a5a};
  endtask
  // no wait-state count assumed: hold until pready, only the cycle ceiling ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(irq, 1'b1)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rdat & 32'hffffff5f, 32'h00000008)
    `CHK(rdat[ST_RBE], 1'b1)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK(rerr, 1'b1)
    $display("test reset done");
    // slow clock keeps words queued so the fifo can fill
    for (int w = 0; w < 3; w++) begin
      apb(1'b1, ADDR_CLKDIV, 32'hff);
      apb(1'b1, ADDR_CTRL, ctrl_val(w[1:0], 1'b1, 2'b00, 1'b0));
      rdat = 32'h0;
      for (int k = 0; k < 20 && rdat[ST_TBF] !== 1'b1; k++) begin
        apb(1'b1, ADDR_DATA, 32'h5a);
        apb(1'b0, ADDR_STATUS, 32'h0);
      end
      `CHK(rdat[20:16], depth_of(w[1:0]))
      `CHK({rdat[ST_BUSY], rdat[ST_SHIFTER_EMPTY_FLAG], rdat[ST_TBE]}, 3'b100)
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK({rdat[20:16], rdat[ST_TBE]}, 6'h01)
    end
    $display("test fill done");
    // half period must cover the sdi synchroniser round trip
    apb(1'b1, ADDR_CLKDIV, {24'h0, CLKDIV_RESET});
    apb(1'b1, ADDR_INT_EN, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wsel = (m == 3) ? WIDTH_32 : m[1:0];
      get_rnd();
      i_ssp_link_partner.tx_word = word;
      i_ssp_link_partner.nbits = (wsel == WIDTH_8) ? 8 : (wsel == WIDTH_16) ? 16 : 32;
      {i_ssp_link_partner.cpha, i_ssp_link_partner.cpol} = m[1:0];
      apb(1'b1, ADDR_CTRL, ctrl_val(wsel, 1'b1, m[1:0], 1'b0));
      get_rnd();
      apb(1'b1, ADDR_DATA, word);
      wait_irq();
      `CHK(i_ssp_link_partner.rx_word & mask_of(wsel), word & mask_of(wsel))
      apb(1'b0, ADDR_DATA, 32'h0);
      `CHK(rdat & mask_of(wsel), i_ssp_link_partner.tx_word & mask_of(wsel))
      apb(1'b1, ADDR_INT_EN, 32'h0);
      apb(1'b0, ADDR_INT_STAT, 32'h0);
      `CHK({irq, rdat[IRQ_XFER]}, 2'b01)
      apb(1'b1, ADDR_INT_CLR, 32'h1);
      apb(1'b1, ADDR_INT_EN, 32'h1);
      apb(1'b0, ADDR_INT_STAT, 32'h0);
      `CHK({irq, rdat[IRQ_XFER]}, 2'b00)
      $display("test master mode %0d done", m);
    end
    // slave role: fifth word meets a full fifo and is dropped
    apb(1'b1, ADDR_CTRL, ctrl_val(WIDTH_32, 1'b0, 2'b00, 1'b0));
    {i_ssp_link_partner.cpha, i_ssp_link_partner.cpol} = 2'b00;
    i_ssp_link_partner.nbits = 32;
    get_rnd();
    exp_tx = word;
    apb(1'b1, ADDR_DATA, exp_tx);
    for (int k = 0; k < 5; k++) begin
      get_rnd();
      sent[k] = word;
      i_ssp_link_partner.tx_word = word;
      i_ssp_link_partner.master_xfer(32);
      wait_irq();
      if (k == 0) `CHK(i_ssp_link_partner.rx_word, exp_tx)
      apb(1'b1, ADDR_INT_CLR, 32'h1);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rdat[28:24], rdat[ST_ROV], rdat[ST_RBE]}, 7'h12)
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ADDR_DATA, 32'h0);
      `CHK(rdat, sent[k])
    end
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h40);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rdat[ST_ROV], rdat[ST_RBE], rdat[28:24]}, 7'h20)
    $display("test overflow done");
    // framed slave: select with empty fifo, released after three clocks
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CTRL, ctrl_val(WIDTH_8, 1'b0, 2'b00, 1'b1));
    i_ssp_link_partner.nbits = 8;
    i_ssp_link_partner.master_xfer(3);
    repeat (8) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rdat[ST_FRAME_ERROR_FLAG], rdat[ST_TUR]}, 2'b11)
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rdat[ST_FRAME_ERROR_FLAG], rdat[ST_TUR]}, 2'b01)
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CTRL, ctrl_val(WIDTH_8, 1'b0, 2'b00, 1'b1));
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rdat[ST_TUR], 1'b0)
    $display("test framed done");
    print_verdict();
  end
endmodule // ssp_tb_top
